// file: src/mcs_pkg.sv
package mcs_pkg;
  localparam int         NUM_CH      = 16;
  localparam int         CH_W        = 4;
  localparam int         LIST_DEPTH  = 16;
  localparam int         PTR_W       = 4;
  localparam logic [3:0] PAIR_OFFSET = 4'h8;
  localparam logic [7:0] CARD_RESET  = 8'h01;
  localparam logic [15:0] ALL_OPEN   = 16'h0000;
  typedef enum logic [1:0] {
    MCS_IDLE  = 2'b00,
    MCS_BREAK = 2'b01,
    MCS_MAKE  = 2'b11
  } mcs_state_t;
endpackage

// file: src/mcs_decode.sv
`timescale 1ns/100ps
module mcs_decode
  import mcs_pkg::*;
(
  input  wire logic [7:0]  card_number_digits,
  input  wire logic [7:0]  channel_number_digits,
  input  wire logic [7:0]  my_card,
  output logic             hit,
  output logic             valid,
  output logic [CH_W-1:0]  ch
);
  // bcd digits: tens in high nibble; leading zeros are just zero nibbles
  logic [7:0] bin;
  always_comb begin
    // widen the tens digit first so the product keeps all of its bits
    bin   = ({4'h0, channel_number_digits[7:4]} * 8'h0a) + {4'h0, channel_number_digits[3:0]};
    hit   = (card_number_digits == my_card);
    valid = (channel_number_digits[3:0] < 4'ha) && (bin < 8'(NUM_CH));
    ch    = bin[CH_W-1:0];
  end
endmodule

// file: src/mcs_top.sv
`timescale 1ns/100ps
module mcs_top
  import mcs_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [7:0]          my_card,
  input  wire logic [7:0]          card_number_digits,
  input  wire logic [7:0]          channel_number_digits,
  input  wire logic                open_request,
  input  wire logic                close_request,
  input  wire logic                list_write,
  input  wire logic [PTR_W-1:0]    list_addr,
  input  wire logic [PTR_W:0]      list_length,
  input  wire logic                scan_start_request,
  input  wire logic                trigger,
  input  wire logic                four_wire_pairing_mode,
  output logic [NUM_CH-1:0]        channel_closed,
  output logic                     busy,
  output logic                     scan_active,
  output logic [PTR_W-1:0]         scan_ptr
);
  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic            hit;
  logic            valid;
  logic [CH_W-1:0] dec_ch;

  mcs_decode u_dec (
    .card_number_digits    (card_number_digits),
    .channel_number_digits (channel_number_digits),
    .my_card               (my_card),
    .hit                   (hit),
    .valid                 (valid),
    .ch                    (dec_ch)
  );

  // ------------------------------------------------------------
  // scan list memory
  // ------------------------------------------------------------
  logic [CH_W-1:0] list_mem [LIST_DEPTH];
  always_ff @(posedge mclk) begin
    if (list_write && hit && valid) begin
      list_mem[list_addr] <= dec_ch;
    end
  end

  function automatic logic [NUM_CH-1:0] pattern(input logic [CH_W-1:0] c, input logic pair);
    logic [NUM_CH-1:0] p;
    p = ALL_OPEN;
    p[c] = 1'b1;
    if (pair) begin
      p[c ^ PAIR_OFFSET] = 1'b1;
    end
    return p;
  endfunction

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  mcs_state_t        state_r, state_nxt;
  logic [NUM_CH-1:0] closed_r, closed_nxt;
  logic [NUM_CH-1:0] target_r, target_nxt;
  logic              scan_r, scan_nxt;
  logic [PTR_W-1:0]  ptr_r, ptr_nxt;
  logic [PTR_W:0]    len_r, len_nxt;
  logic              busy_r, busy_nxt;

  // ------------------------------------------------------------
  // request qualification
  // ------------------------------------------------------------
  // requests count only while idle; a strobe during a switch is dropped,
  // which keeps a second close from cutting the break phase short
  logic idle;
  logic addr_ok;
  logic close_hit;
  logic open_hit;
  logic do_close;
  logic do_open;
  logic do_start;
  logic do_step;
  logic last_entry;

  always_comb begin
    idle       = (state_r == MCS_IDLE);
    addr_ok    = hit && valid;
    close_hit  = close_request && addr_ok;
    open_hit   = open_request && addr_ok;
    // fixed priority: close, open, scan start, trigger
    do_close   = idle && close_hit;
    do_open    = idle && !close_hit && open_hit;
    do_start   = idle && !close_hit && !open_hit && scan_start_request
                 && (list_length != '0);
    do_step    = idle && !close_hit && !open_hit && !do_start && trigger && scan_r;
    // wraps to the list head after the last entry
    last_entry = (({1'b0, ptr_r} + 5'h01) >= len_r);
  end

  // ------------------------------------------------------------
  // switch phase: break, then make
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MCS_IDLE: begin
        if (do_close || do_start || do_step) begin
          state_nxt = MCS_BREAK;
        end
      end
      MCS_BREAK: begin
        state_nxt = MCS_MAKE;
      end
      MCS_MAKE: begin
        state_nxt = MCS_IDLE;
      end
      default: begin
        state_nxt = MCS_IDLE;
      end
    endcase
    // taken from the next state so busy rises together with the break phase
    busy_nxt = (state_nxt != MCS_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= MCS_IDLE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // ------------------------------------------------------------
  // scan list pointer
  // ------------------------------------------------------------
  always_comb begin
    scan_nxt = scan_r;
    ptr_nxt  = ptr_r;
    len_nxt  = len_r;
    if (do_close) begin
      // a direct close takes the card out of its scan
      scan_nxt = 1'b0;
    end else if (do_start) begin
      ptr_nxt  = '0;
      len_nxt  = list_length;
      scan_nxt = 1'b1;
    end else if (do_step) begin
      ptr_nxt  = last_entry ? '0 : ptr_r + 4'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scan_r <= 1'b0;
      ptr_r  <= '0;
      len_r  <= '0;
    end else begin
      scan_r <= scan_nxt;
      ptr_r  <= ptr_nxt;
      len_r  <= len_nxt;
    end
  end

  // ------------------------------------------------------------
  // channel pattern
  // ------------------------------------------------------------
  // the new pattern waits in target_r while the break phase opens the card
  always_comb begin
    target_nxt = target_r;
    closed_nxt = closed_r;
    case (state_r)
      MCS_IDLE: begin
        if (do_close) begin
          target_nxt = pattern(dec_ch, four_wire_pairing_mode);
        end else if (do_open) begin
          // only the addressed channel and, when paired, its partner open
          closed_nxt = closed_r & ~pattern(dec_ch, four_wire_pairing_mode);
        end else if (do_start) begin
          target_nxt = pattern(list_mem[0], four_wire_pairing_mode);
        end else if (do_step) begin
          target_nxt = pattern(list_mem[ptr_nxt], four_wire_pairing_mode);
        end
      end
      MCS_BREAK: begin
        closed_nxt = ALL_OPEN;
      end
      MCS_MAKE: begin
        closed_nxt = target_r;
      end
      default: begin
        closed_nxt = ALL_OPEN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      closed_r <= ALL_OPEN;
      target_r <= ALL_OPEN;
    end else begin
      closed_r <= closed_nxt;
      target_r <= target_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from registers
  // ------------------------------------------------------------
  assign channel_closed = closed_r;
  assign busy           = busy_r;
  assign scan_active    = scan_r;
  assign scan_ptr       = ptr_r;
endmodule

// file: test/mcs_top_properties.sv
`timescale 1ns/100ps
// ----
// port checker
// ----
module mcs_top_properties
  import mcs_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              four_wire_pairing_mode,
  input wire logic [NUM_CH-1:0] channel_closed,
  input wire logic              busy
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_ONE: assert property (!four_wire_pairing_mode |-> $onehot0(channel_closed))
    else $error("more than one channel closed");
  AST_TWO: assert property ($countones(channel_closed) <= 2)
    else $error("more than two channels closed");
  AST_BBM: assert property (|$past(channel_closed)
    |-> (channel_closed & ~$past(channel_closed)) == ALL_OPEN) else $error("make before break");
  AST_RST: assert property ($past(rst) |-> channel_closed == ALL_OPEN)
    else $error("channel closed out of reset");
  AST_BUSY: assert property ($rose(busy) |=> busy ##1 !busy)
    else $error("switch sequence length wrong");
  AST_BRK: assert property ($rose(busy) |=> channel_closed == ALL_OPEN)
    else $error("old channel not opened first");
  AST_MAKE: assert property (|(channel_closed & ~$past(channel_closed)) |-> $past(busy))
    else $error("closed without break phase");
  AST_FOUR_WIRE_PAIRING_MODE: assert property ((four_wire_pairing_mode && $changed(channel_closed))
    |-> channel_closed[7:0] == channel_closed[15:8]) else $error("partner not paired");
  CV_SWITCH: cover property ($rose(busy));
  CV_PAIR: cover property (four_wire_pairing_mode && |channel_closed);
  CV_OPEN: cover property ($fell(|channel_closed) && !busy);
endmodule
bind mcs_top mcs_top_properties chk (.mclk, .rst, .four_wire_pairing_mode, .channel_closed, .busy);

// file: test/mcs_host.sv
`timescale 1ns/100ps
// ----
// command interpreter model
// ----
module mcs_host (
  input  wire logic  mclk,
  output logic [7:0] card_number_digits,
  output logic [7:0] channel_number_digits,
  output logic [4:0] reqs,
  output logic [3:0] list_addr
);
  initial reqs = 5'h00;
  // bcd card digits then channel digits; card one is the lowest card
  task automatic send(input int k, input logic [7:0] c, n, input logic [3:0] a);
    @(negedge mclk);
    {card_number_digits, channel_number_digits, list_addr} = {c, n, a};
    reqs = 5'h01 << k;
    @(negedge mclk);
    reqs = 5'h00;
    // released lines carry the inverse so stale digits never look valid
    {card_number_digits, channel_number_digits, list_addr} = ~{c, n, a};
  endtask
endmodule

// file: test/tb.sv
`timescale 1ns/100ps
module tb;
  import mcs_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        pair = 1'b0;
  logic [7:0]  cc, nn;
  logic [4:0]  r;
  logic [3:0]  la, ptr;
  logic [15:0] cl;
  logic        busy;
  logic        sa;
  int          miscompares = 0;
  int          compares = 0;
  always #5 mclk = ~mclk;
  mcs_host host (.mclk(mclk), .card_number_digits(cc), .channel_number_digits(nn), .reqs(r),
    .list_addr(la));
  mcs_top uut (.mclk(mclk), .rst(rst), .my_card(8'h01), .card_number_digits(cc),
    .channel_number_digits(nn), .close_request(r[0]), .open_request(r[1]), .list_write(r[2]),
    .scan_start_request(r[3]), .trigger(r[4]), .list_addr(la), .list_length(5'h03),
    .four_wire_pairing_mode(pair), .channel_closed(cl), .busy(busy), .scan_active(sa),
    .scan_ptr(ptr));
  task automatic chk(input string s, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic settle();
    for (int i = 0; i < 8 && busy !== 1'b0; i++) @(negedge mclk);
    if (busy !== 1'b0) chk("busy", 16'h0000, 16'h0001);
    if (busy !== 1'b0) complete_run();
  endtask
  task automatic go(input int k, input logic [7:0] c, n, input logic [3:0] a);
    host.send(k, c, n, a);
    settle();
  endtask
  task automatic t_close();
    go(0, 8'h01, 8'h02, 4'h0);
    chk("close", 16'h0004, cl);
    go(0, 8'h02, 8'h03, 4'h0);
    chk("other card", 16'h0004, cl);
    host.send(0, 8'h01, 8'h15, 4'h0);
    @(negedge mclk);
    chk("break", ALL_OPEN, cl);
    settle();
    chk("make", 16'h8000, cl);
    go(1, 8'h01, 8'h15, 4'h0);
    chk("open", ALL_OPEN, cl);
  endtask
  task automatic t_pair();
    pair = 1'b1;
    go(0, 8'h01, 8'h02, 4'h0);
    chk("pair", 16'h0404, cl);
    go(1, 8'h01, 8'h10, 4'h0);
    chk("pair open", ALL_OPEN, cl);
    pair = 1'b0;
  endtask
  task automatic t_scan();
    go(2, 8'h01, 8'h05, 4'h0);
    go(2, 8'h01, 8'h12, 4'h1);
    go(2, 8'h01, 8'h00, 4'h2);
    go(3, 8'h01, 8'h00, 4'h0);
    chk("start", 16'h0020, cl);
    chk("scan on", 16'h0001, {15'h0000, sa});
    go(4, 8'h01, 8'h00, 4'h0);
    chk("step", 16'h1000, cl);
    go(4, 8'h01, 8'h00, 4'h0);
    chk("ptr", 16'h0002, {12'h000, ptr});
    go(4, 8'h01, 8'h00, 4'h0);
    chk("wrap", 16'h0020, cl);
    go(0, 8'h01, 8'h03, 4'h0);
    chk("scan off", 16'h0000, {15'h0000, sa});
    go(4, 8'h01, 8'h00, 4'h0);
    chk("idle trigger", 16'h0008, cl);
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    chk("reset", ALL_OPEN, cl);
    t_close();
    t_pair();
    t_scan();
    complete_run();
  end
endmodule
